// ===== logic/wdsm_map.svh
`ifndef WDSM_MAP_SVH
`define WDSM_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define WDSM_OFF_CTRL      12'h000
`define WDSM_OFF_STATUS    12'h004
`define WDSM_OFF_INT_STAT  12'h008
`define WDSM_OFF_INT_MASK  12'h00c
`define WDSM_OFF_COUNT     12'h010

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WDSM_CTRL_SWEN     0
`define WDSM_CTRL_PS_LO    1
`define WDSM_CTRL_PS_HI    5
`define WDSM_ST_TIMEOUT    0
`define WDSM_ST_POWERDOWN  1
`define WDSM_ST_WDRST_N    2
`define WDSM_INT_WAKE      0
`define WDSM_INT_RESET     1

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define WDSM_PS_RESET      5'h0b
`define WDSM_PS_MAX        5'h12
`define WDSM_OSC_KHZ       31
`define WDSM_TICK_MS       1

`endif

// ===== logic/wdsm_pkg.sv
package wdsm_pkg;

	// Watchdog mode codes from the configuration field
	typedef enum logic [1:0]
	{
		WDSM_MODE_OFF    = 2'b00,
		WDSM_MODE_SW     = 2'b01,
		WDSM_MODE_NOSLP  = 2'b10,
		WDSM_MODE_ALWAYS = 2'b11
	} wdsm_mode_t;

	// Reset request holding state, one-hot
	typedef enum logic [1:0]
	{
		WDSM_RQ_IDLE = 2'b01,
		WDSM_RQ_HOLD = 2'b10
	} wdsm_rq_t;

	// Reset-source and status flags
	typedef struct packed
	{
		logic watchdog_reset_flag_n;
		logic powerdown_flag;
		logic timeout_flag;
	} wdsm_flags_t;

	// Device-side events seen by the watchdog
	typedef struct packed
	{
		logic sleep_mode;
		logic clear_watchdog_instr;
		logic osc_fail;
	} wdsm_dev_t;

endpackage

// ===== logic/wdsm_watchdog.sv
`include "wdsm_map.svh"

module wdsm_watchdog
	import wdsm_pkg::*;
#(
	parameter int OSC_EDGES_PER_MS = `WDSM_OSC_KHZ * `WDSM_TICK_MS
)
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        low_freq_internal_osc,
	input  wire logic [1:0]  wdt_mode_cfg,
	input  wire wdsm_dev_t   dev,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             device_reset_req,
	output logic             wake_req,
	output logic             irq
);

	// Prescaler is 8 bits and needs at least two edges per tick
	if (OSC_EDGES_PER_MS < 2 || OSC_EDGES_PER_MS > 255)
	begin
		$error("OSC_EDGES_PER_MS out of range");
	end

	// ----------------------------------------
	// Reset release and oscillator sync
	// ----------------------------------------
	logic       rst_s1;
	logic       rst_n;
	logic [2:0] osc_sync;

	// Two-stage reset release
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// Oscillator pin: two sync stages then an edge history stage
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			osc_sync <= 3'h0;
		else
			osc_sync <= {osc_sync[1:0], low_freq_internal_osc};
	end

	wire osc_edge = osc_sync[1] & ~osc_sync[2];

	// ----------------------------------------
	// Registers and mode decode
	// ----------------------------------------
	logic        sw_watchdog_enable;
	logic [4:0]  watchdog_period_select;
	wdsm_flags_t flags;
	logic [1:0]  int_stat;
	logic [1:0]  int_mask;
	logic [7:0]  presc;
	logic [18:0] count;
	logic        sleep_q;
	wdsm_rq_t    rq_state;

	// Whether the watchdog runs for a mode, enable and sleep state
	function automatic logic wd_active(input logic [1:0] m, input logic en, input logic slp);
		logic r;
		r = 1'b0;
		case (wdsm_mode_t'(m))
			WDSM_MODE_ALWAYS: r = 1'b1;
			WDSM_MODE_NOSLP:  r = ~slp;
			WDSM_MODE_SW:     r = en;
			default:          r = 1'b0;
		endcase
		return r;
	endfunction

	wire active      = wd_active(wdt_mode_cfg, sw_watchdog_enable, dev.sleep_mode);
	wire sleep_enter = dev.sleep_mode & ~sleep_q;
	wire sleep_exit  = ~dev.sleep_mode & sleep_q;

	// ----------------------------------------
	// Tick and time-out
	// ----------------------------------------
	// Period limit in ms ticks: 2^ps, ps clamped at 18 (262144 ms)
	wire [4:0]  ps_eff  = (watchdog_period_select > `WDSM_PS_MAX) ? `WDSM_PS_MAX
	                      : watchdog_period_select;
	wire [18:0] last_ms = 19'((20'h00001 << ps_eff) - 20'h00001);
	wire        tick    = active & osc_edge
	                      & (presc == 8'(OSC_EDGES_PER_MS - 1));
	wire        timeout = tick & (count == last_ms);

	// Every clearing source; divider select is deliberately absent
	wire wd_clear = dev.clear_watchdog_instr | dev.osc_fail | sleep_enter
	                | sleep_exit | ~active | timeout;

	// Oscillator edge prescaler, restarts on any clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			presc <= 8'h00;
		else if (wd_clear || tick)
			presc <= 8'h00;
		else if (osc_edge)
			presc <= presc + 8'h01;
	end

	// Millisecond count, restarts from zero after sleep entry
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			count <= 19'h00000;
		else if (wd_clear)
			count <= 19'h00000;
		else if (tick)
			count <= count + 19'h00001;
	end

	// Sleep edge history
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sleep_q <= 1'b0;
		else
			sleep_q <= dev.sleep_mode;
	end

	// ----------------------------------------
	// Reset request and wake
	// ----------------------------------------
	// Reset request held until the next oscillator edge
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rq_state <= WDSM_RQ_IDLE;
		else
		begin
			case (rq_state)
				WDSM_RQ_IDLE:
					if (timeout && !dev.sleep_mode)
						rq_state <= WDSM_RQ_HOLD;
				WDSM_RQ_HOLD:
					if (osc_edge)
						rq_state <= WDSM_RQ_IDLE;
				default:
					rq_state <= WDSM_RQ_IDLE;
			endcase
		end
	end

	assign device_reset_req = (rq_state == WDSM_RQ_HOLD);

	// Wake pulse for a time-out during sleep
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			wake_req <= 1'b0;
		else
			wake_req <= timeout & dev.sleep_mode;
	end

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire wr_en     = psel & penable & pwrite;
	wire rd_en     = psel & penable & ~pwrite;
	wire sel_ctrl  = (paddr == `WDSM_OFF_CTRL);
	wire sel_stat  = (paddr == `WDSM_OFF_STATUS);
	wire sel_istat = (paddr == `WDSM_OFF_INT_STAT);
	wire sel_imask = (paddr == `WDSM_OFF_INT_MASK);
	wire sel_count = (paddr == `WDSM_OFF_COUNT);
	wire mapped    = sel_ctrl | sel_stat | sel_istat | sel_imask | sel_count;

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// Control register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sw_watchdog_enable     <= 1'b0;
			watchdog_period_select <= `WDSM_PS_RESET;
		end
		else if (wr_en && sel_ctrl)
		begin
			sw_watchdog_enable     <= pwdata[`WDSM_CTRL_SWEN];
			watchdog_period_select <= pwdata[`WDSM_CTRL_PS_HI:`WDSM_CTRL_PS_LO];
		end
	end

	// Status flags; hardware set wins over a software clear
	wire wst = wr_en & sel_stat;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			flags <= 3'b100;
		else
		begin
			flags.timeout_flag   <= timeout
				| (flags.timeout_flag & ~(wst & pwdata[`WDSM_ST_TIMEOUT]));
			flags.powerdown_flag <= (timeout & dev.sleep_mode)
				| (flags.powerdown_flag & ~(wst & pwdata[`WDSM_ST_POWERDOWN]));
			flags.watchdog_reset_flag_n <= ~(timeout & ~dev.sleep_mode)
				& (flags.watchdog_reset_flag_n | (wst & pwdata[`WDSM_ST_WDRST_N]));
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	wire [1:0] int_ev;
	assign int_ev[`WDSM_INT_WAKE]  = timeout & dev.sleep_mode;
	assign int_ev[`WDSM_INT_RESET] = timeout & ~dev.sleep_mode;

	// Sticky bits; a read clears only the bits it reported, set wins
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			int_stat <= 2'h0;
		else
			int_stat <= int_ev | (int_stat & ~(prdata[1:0] & {2{rd_en & sel_istat}}));
	end

	// Mask register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			int_mask <= 2'h0;
		else if (wr_en && sel_imask)
			int_mask <= pwdata[1:0];
	end

	assign irq = |(int_stat & int_mask);

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	wire [31:0] rd_mux = sel_ctrl  ? {26'h0, watchdog_period_select, sw_watchdog_enable}
	                   : sel_stat  ? {29'h0, flags}
	                   : sel_istat ? {30'h0, int_stat}
	                   : sel_imask ? {30'h0, int_mask}
	                   : sel_count ? {13'h0, count}
	                   : 32'h0;

	// Registered read data, loaded in the setup cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			prdata <= 32'h0;
		else if (psel && !penable)
			prdata <= rd_mux;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	localparam int RQ_MAX = 1000;

	property p_off;
		@(posedge clk) disable iff (!rst_n)
		wdt_mode_cfg == 2'b00 |-> !active ##1 count == 19'h0;
	endproperty
	a_off: assert property (p_off) else $error("mode 00 not off");

	property p_always;
		@(posedge clk) disable iff (!rst_n)
		wdt_mode_cfg == 2'b11 |-> active;
	endproperty
	a_always: assert property (p_always) else $error("mode 11 not on");

	property p_noslp;
		@(posedge clk) disable iff (!rst_n)
		wdt_mode_cfg == 2'b10 |-> active == !dev.sleep_mode;
	endproperty
	a_noslp: assert property (p_noslp) else $error("mode 10 wrong");

	property p_sw;
		@(posedge clk) disable iff (!rst_n)
		wdt_mode_cfg == 2'b01 |-> active == sw_watchdog_enable;
	endproperty
	a_sw: assert property (p_sw) else $error("mode 01 wrong");

	property p_hold;
		@(posedge clk) disable iff (!rst_n)
		!tick && !wd_clear |=> $stable(count);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved without tick");

	property p_ps;
		@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> watchdog_period_select == `WDSM_PS_RESET && last_ms == 19'h007ff;
	endproperty
	a_ps: assert property (p_ps) else $error("reset period not 2048 ms");

	property p_clr;
		@(posedge clk) disable iff (!rst_n)
		dev.clear_watchdog_instr || sleep_enter |=> count == 19'h0;
	endproperty
	a_clr: assert property (p_clr) else $error("count not cleared");

	property p_sleep_to;
		@(posedge clk) disable iff (!rst_n)
		timeout && dev.sleep_mode |=> wake_req && !device_reset_req
			&& flags.timeout_flag && flags.powerdown_flag;
	endproperty
	a_sleep_to: assert property (p_sleep_to) else $error("sleep time-out wrong");

	property p_awake_to;
		@(posedge clk) disable iff (!rst_n)
		timeout && !dev.sleep_mode |=> device_reset_req
			&& !flags.watchdog_reset_flag_n && count == 19'h0;
	endproperty
	a_awake_to: assert property (p_awake_to) else $error("awake time-out wrong");

	property p_rq_len;
		@(posedge clk) disable iff (!rst_n)
		$rose(device_reset_req) |-> ##[1:RQ_MAX] !device_reset_req;
	endproperty
	a_rq_len: assert property (p_rq_len) else $error("reset request length");

	property p_rq_end;
		@(posedge clk) disable iff (!rst_n)
		device_reset_req |=> device_reset_req != $past(osc_edge);
	endproperty
	a_rq_end: assert property (p_rq_end) else $error("reset request end");

endmodule

// ===== bench/tb_watchdog_timer_with_sleep_modes.sv
`include "wdsm_map.svh"

module tb_watchdog_timer_with_sleep_modes import wdsm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// Stimulus signals
	// ----------------------------------------
	localparam int EPM = 2;
	localparam int TK  = EPM * 20;
	logic        clk     = 1'b0;
	logic        resetn  = 1'b1;
	logic        osc     = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic [1:0]  mode    = 2'b00;
	wdsm_dev_t   dev_s   = '0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        device_reset_req;
	logic        wake_req;
	logic        irq;
	logic        rq_q    = 1'b0;
	int          oc      = 0;
	int          n_rst   = 0;
	int          n_wake  = 0;
	int          fails   = 0;
	int          compares = 0;

	wdsm_watchdog #(.OSC_EDGES_PER_MS(EPM)) DUT (.clk(clk), .resetn(resetn),
		.low_freq_internal_osc(osc), .wdt_mode_cfg(mode), .dev(dev_s),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.device_reset_req(device_reset_req), .wake_req(wake_req), .irq(irq));

	// Clock and free-running slow oscillator, period 20 clk
	always #25 clk = ~clk;
	always @(posedge clk)
	begin
		oc <= (oc == 9) ? 0 : oc + 1;
		if (oc == 9)
			osc <= ~osc;
	end

	// Event monitor
	always @(posedge clk)
	begin
		rq_q <= device_reset_req;
		if (device_reset_req === 1'b1 && rq_q !== 1'b1)
			n_rst++;
		if (wake_req === 1'b1)
			n_wake++;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic wd_on(input logic [1:0] m, input logic sw, input logic sl);
		case (m)
			2'b11: return 1'b1;
			2'b10: return ~sl;
			2'b01: return sw;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] st_exp(input logic r, input logic w);
		return r ? 32'h1 : (w ? 32'h7 : 32'h4);
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wrap_up();
		if (fails == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// APB transfer, held until pready at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic do_reset(input int n);
		resetn <= 1'b0;
		repeat (n) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	task automatic pulse(input int k);
		@(posedge clk);
		if (k == 0)
			dev_s.clear_watchdog_instr <= 1'b1;
		else
			dev_s.osc_fail <= 1'b1;
		@(posedge clk);
		dev_s.clear_watchdog_instr <= 1'b0;
		dev_s.osc_fail <= 1'b0;
	endtask

	// Watchdog against hangs
	initial
	begin
		repeat (60000) @(posedge clk);
		fails++;
		wrap_up();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] r;
		logic        e;
		logic        on;
		logic        rr;
		logic        ww;
		logic        sl;
		logic [1:0]  msk;
		logic [3:0]  c;
		int          n;
		int          ps;
		int          b_rst;
		int          b_wake;
		void'($urandom(30286));
		do_reset(20);
		check("pready", pready, 32'h1);
		apb(1'b0, `WDSM_OFF_CTRL, 32'h0, r, e);
		check("ctrl_reset", r, 32'h16);
		apb(1'b0, `WDSM_OFF_STATUS, 32'h0, r, e);
		check("status_reset", r, 32'h4);
		apb(1'b0, 12'h020, 32'h0, r, e);
		check("unmapped_err", e, 1'b1);
		// Every mode, enable and sleep combination, random mask
		for (int i = 0; i < 16; i++)
		begin
			c = i[3:0];
			msk = 2'($urandom_range(3, 0));
			apb(1'b1, `WDSM_OFF_CTRL, 32'h2 | c[2], r, e);
			apb(1'b1, `WDSM_OFF_STATUS, 32'h7, r, e);
			apb(1'b0, `WDSM_OFF_INT_STAT, 32'h0, r, e);
			apb(1'b1, `WDSM_OFF_INT_MASK, {30'h0, msk}, r, e);
			b_rst = n_rst;
			b_wake = n_wake;
			mode <= c[1:0];
			dev_s.sleep_mode <= c[3];
			repeat (200) @(posedge clk);
			mode <= 2'b00;
			dev_s.sleep_mode <= 1'b0;
			repeat (30) @(posedge clk);
			on = wd_on(c[1:0], c[2], c[3]);
			rr = on & ~c[3];
			ww = on & c[3];
			check("reset_seen", n_rst != b_rst, rr);
			check("wake_seen", n_wake != b_wake, ww);
			check("irq", irq, |({rr, ww} & msk));
			apb(1'b0, `WDSM_OFF_STATUS, 32'h0, r, e);
			check("status", r, st_exp(rr, ww));
			apb(1'b0, `WDSM_OFF_INT_STAT, 32'h0, r, e);
			check("int_stat", r, {30'h0, rr, ww});
			@(posedge clk);
			check("irq_cleared", irq, 1'b0);
			apb(1'b0, `WDSM_OFF_COUNT, 32'h0, r, e);
			check("count_off", r, 32'h0);
		end
		// Time-out moment for random periods, awake and asleep
		for (int i = 0; i < 6; i++)
		begin
			ps = $urandom_range(3, 0);
			sl = 1'($urandom_range(1, 0));
			apb(1'b1, `WDSM_OFF_CTRL, ps << 1, r, e);
			mode <= 2'b11;
			dev_s.sleep_mode <= sl;
			n = 0;
			while (!(sl ? wake_req === 1'b1 : device_reset_req === 1'b1) && n < 2000)
			begin
				@(posedge clk);
				n++;
			end
			check("timeout_at", n >= TK * 2 ** ps - 25 && n <= TK * 2 ** ps + 10, 1'b1);
			if (!sl)
			begin
				n = 0;
				while (device_reset_req === 1'b1 && n < 100)
				begin
					@(posedge clk);
					n++;
				end
				check("req_len", n >= 1 && n <= 24, 1'b1);
			end
			mode <= 2'b00;
			dev_s.sleep_mode <= 1'b0;
			repeat (5) @(posedge clk);
		end
		// Clear sources keep the count from expiring
		apb(1'b1, `WDSM_OFF_CTRL, 32'h2, r, e);
		b_rst = n_rst;
		b_wake = n_wake;
		mode <= 2'b11;
		for (int i = 0; i < 8; i++)
		begin
			repeat (48) @(posedge clk);
			if (i % 3 == 2)
				dev_s.sleep_mode <= ~dev_s.sleep_mode;
			else
				pulse(i % 3);
		end
		repeat (40) @(posedge clk);
		check("no_reset", n_rst, b_rst);
		check("no_wake", n_wake, b_wake);
		// Reset in mid-run
		apb(1'b1, `WDSM_OFF_CTRL, 32'h5, r, e);
		repeat (20) @(posedge clk);
		do_reset(3);
		apb(1'b0, `WDSM_OFF_CTRL, 32'h0, r, e);
		check("ctrl_rereset", r, 32'h16);
		apb(1'b0, `WDSM_OFF_COUNT, 32'h0, r, e);
		check("count_rereset", r <= 32'h1, 1'b1);
		wrap_up();
	end
endmodule
